// >>> ach_pkg.sv
// package: constants and types for the cell header register block
package ach_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] ACH_IDX_FIELD_SEL = 6'h09;
  localparam logic [5:0] ACH_IDX_TX_HDR1 = 6'h10;
  localparam logic [5:0] ACH_IDX_TX_HDR2 = 6'h11;
  localparam logic [5:0] ACH_IDX_TX_HDR3 = 6'h12;
  localparam logic [5:0] ACH_IDX_TX_HDR4 = 6'h13;
  localparam logic [5:0] ACH_IDX_IDLE_HDR1 = 6'h14;
  localparam logic [5:0] ACH_IDX_IDLE_HDR2 = 6'h15;
  localparam logic [5:0] ACH_IDX_IDLE_HDR3 = 6'h16;
  localparam logic [5:0] ACH_IDX_IDLE_HDR4 = 6'h17;
  localparam logic [5:0] ACH_IDX_RX_HDR1 = 6'h18;
  localparam logic [5:0] ACH_IDX_RX_HDR4 = 6'h1B;
  localparam logic [5:0] ACH_IDX_RX_MSK1 = 6'h1C;
  localparam logic [5:0] ACH_IDX_RX_MSK4 = 6'h1F;
  localparam logic [5:0] ACH_IDX_MODE = 6'h20;
  localparam logic [5:0] ACH_IDX_STATUS = 6'h21;

  // header byte bank spans indices 0x10 to 0x1F
  localparam int ACH_BANK_SIZE = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ACH_RST_HDR = 8'h00;
  localparam logic [7:0] ACH_RST_IDLE4 = 8'h01;
  localparam logic [7:0] ACH_RST_MSK = 8'hFF;
  localparam logic [7:0] ACH_RST_FIELD_SEL = 8'h00;
  localparam logic [7:0] ACH_RST_MODE = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ACH_SEL_GFC = 0;
  localparam int ACH_SEL_VPI = 1;
  localparam int ACH_SEL_VCI = 2;
  localparam int ACH_SEL_PT = 3;
  localparam int ACH_SEL_CLP = 4;
  localparam int ACH_MODE_NNI = 0;
  localparam int ACH_CLP_BIT = 0;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] ACH_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACH_RESP_SLVERR = 2'h2;

  // octet 1 is the most significant byte
  typedef struct packed {
    logic [3:0] gfc_vpi;
    logic [7:0] vpi;
    logic [15:0] vci;
    logic [2:0] pt;
    logic clp;
  } ach_hdr_type;

endpackage

// >>> ach_hdr_screen.sv
// module: masked compare of a received cell header against a reference
`timescale 1ns/1ns
module ach_hdr_screen
  import ach_pkg::*;
(
  input wire logic [31:0] rx_hdr,
  input wire logic [31:0] match_hdr,
  input wire logic [31:0] ignore_mask,
  output logic [3:0] octet_match,
  output logic hdr_match
);

  // ----------------------------------------------------------------
  // per octet compare
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_octet
      // a set mask bit lets either value through
      assign octet_match[i] = (((rx_hdr[8*i +: 8] ^ match_hdr[8*i +: 8])
        & ~ignore_mask[8*i +: 8]) == 8'h00);
    end
  endgenerate

  assign hdr_match = &octet_match;

endmodule // ach_hdr_screen

// >>> ach_hdr_regs.sv
// module: cell header registers, transmit insertion and receive screening
//
// Contract
// - user header is four consecutive byte registers
// - insert stored bits only in selected fields
// - idle cells carry the separate idle header
// - octet 1 upper nibble GFC (UNI), VPI (NNI)
// - CLP sits at octet 4 bit 0
// - idle octet 4 resets to 0x01, others zero
// - forward cell only on header match
// - mask further qualifies the header compare
// - mask bit one ignores that header bit
`timescale 1ns/1ns
module ach_hdr_regs
  import ach_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int COUNT_WIDTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transmit cell headers
  input wire ach_hdr_type tx_in_hdr,
  input wire logic tx_in_valid,
  input wire logic tx_in_idle,
  output ach_hdr_type tx_out_hdr,
  output logic tx_out_valid,
  output logic tx_out_idle,
  // receive cell headers
  input wire ach_hdr_type rx_in_hdr,
  input wire logic rx_in_valid,
  output ach_hdr_type rx_fwd_hdr,
  output logic rx_fwd_valid,
  output logic rx_drop
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] hdr_bank [ACH_BANK_SIZE];
  logic [7:0] header_field_select;
  logic [7:0] mode;
  logic [COUNT_WIDTH-1:0] accept_count;
  logic [COUNT_WIDTH-1:0] drop_count;

  // ----------------------------------------------------------------
  // write channel state
  // ----------------------------------------------------------------
  logic aw_held;
  logic [5:0] aw_index;
  logic aw_ok;
  logic w_held;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;

  // ----------------------------------------------------------------
  // address decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [ADDR_WIDTH-1:0] addr);
    // bits above the 8-bit register window must be clear; a shift keeps
    // the test legal when the bus is exactly 8 bits wide
    in_range = ((addr >> 8) == '0);
  endfunction

  function automatic logic is_writable(input logic [5:0] idx);
    is_writable = (idx == ACH_IDX_FIELD_SEL) || (idx == ACH_IDX_MODE)
      || ((idx >= ACH_IDX_TX_HDR1) && (idx <= ACH_IDX_RX_MSK4));
  endfunction

  function automatic logic is_readable(input logic [5:0] idx);
    is_readable = is_writable(idx) || (idx == ACH_IDX_STATUS);
  endfunction

  function automatic logic [7:0] bank_reset(input int slot);
    logic [5:0] idx;
    idx = ACH_IDX_TX_HDR1 + 6'(slot);
    if (idx == ACH_IDX_IDLE_HDR4) begin
      bank_reset = ACH_RST_IDLE4;
    end else if (idx >= ACH_IDX_RX_MSK1) begin
      bank_reset = ACH_RST_MSK;
    end else begin
      bank_reset = ACH_RST_HDR;
    end
  endfunction

  // ----------------------------------------------------------------
  // axi write address and data capture
  // ----------------------------------------------------------------
  // each channel is taken on its own; the response waits for both
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_index <= 6'h00;
      aw_ok <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_index <= s_axi_awaddr[7:2];
      aw_ok <= in_range(s_axi_awaddr) && is_writable(s_axi_awaddr[7:2]);
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // write response
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ACH_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= aw_ok ? ACH_RESP_OKAY : ACH_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // header byte bank
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ACH_BANK_SIZE; g++) begin : g_bank
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          hdr_bank[g] <= bank_reset(g);
        end else if (do_write && aw_ok && w_lane0
          && (aw_index == ACH_IDX_TX_HDR1 + 6'(g))) begin
          hdr_bank[g] <= w_byte;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      header_field_select <= ACH_RST_FIELD_SEL;
    end else if (do_write && aw_ok && w_lane0 && (aw_index == ACH_IDX_FIELD_SEL)) begin
      header_field_select <= w_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= ACH_RST_MODE;
    end else if (do_write && aw_ok && w_lane0 && (aw_index == ACH_IDX_MODE)) begin
      mode <= w_byte;
    end
  end

  // ----------------------------------------------------------------
  // axi read
  // ----------------------------------------------------------------
  logic [5:0] ar_index;
  logic [31:0] read_word;
  logic read_ok;

  assign ar_index = s_axi_araddr[7:2];
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    read_ok = in_range(s_axi_araddr) && is_readable(ar_index);
    read_word = 32'h0000_0000;
    if (!read_ok) begin
      read_word = 32'h0000_0000;
    end else if (ar_index == ACH_IDX_FIELD_SEL) begin
      read_word = {24'h000000, header_field_select};
    end else if (ar_index == ACH_IDX_MODE) begin
      read_word = {24'h000000, mode};
    end else if (ar_index == ACH_IDX_STATUS) begin
      read_word = {16'(drop_count), 16'(accept_count)};
    end else begin
      read_word = {24'h000000, hdr_bank[4'(ar_index - ACH_IDX_TX_HDR1)]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ACH_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word;
      s_axi_rresp <= read_ok ? ACH_RESP_OKAY : ACH_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assembled 32-bit headers, octet 1 most significant
  // ----------------------------------------------------------------
  logic [31:0] tx_stored;
  logic [31:0] idle_stored;
  logic [31:0] rx_match_hdr;
  logic [31:0] rx_ignore;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      tx_stored[31-8*k -: 8] = hdr_bank[k];
      idle_stored[31-8*k -: 8] = hdr_bank[4+k];
      rx_match_hdr[31-8*k -: 8] = hdr_bank[8+k];
      rx_ignore[31-8*k -: 8] = hdr_bank[12+k];
    end
  end

  // ----------------------------------------------------------------
  // transmit insertion mask from the field select bits
  // ----------------------------------------------------------------
  ach_hdr_type insert_mask;
  logic upper_sel;

  // upper nibble of octet 1 follows the vpi select under nni
  assign upper_sel = mode[ACH_MODE_NNI] ? header_field_select[ACH_SEL_VPI]
    : header_field_select[ACH_SEL_GFC];

  always_comb begin
    insert_mask.gfc_vpi = {4{upper_sel}};
    insert_mask.vpi = {8{header_field_select[ACH_SEL_VPI]}};
    insert_mask.vci = {16{header_field_select[ACH_SEL_VCI]}};
    insert_mask.pt = {3{header_field_select[ACH_SEL_PT]}};
    insert_mask.clp = header_field_select[ACH_SEL_CLP];
  end

  // ----------------------------------------------------------------
  // transmit path, one cycle latency
  // ----------------------------------------------------------------
  logic [31:0] next_tx_hdr;

  always_comb begin
    if (tx_in_idle) begin
      next_tx_hdr = idle_stored;
    end else begin
      next_tx_hdr = (tx_stored & insert_mask) | (tx_in_hdr & ~insert_mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_out_valid <= 1'b0;
      tx_out_idle <= 1'b0;
      tx_out_hdr <= '0;
    end else begin
      tx_out_valid <= tx_in_valid;
      if (tx_in_valid) begin
        tx_out_hdr <= next_tx_hdr;
        tx_out_idle <= tx_in_idle;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive screening, one cycle latency
  // ----------------------------------------------------------------
  logic rx_hit;

  ach_hdr_screen u_screen (
    .rx_hdr(rx_in_hdr),
    .match_hdr(rx_match_hdr),
    .ignore_mask(rx_ignore),
    .octet_match(),
    .hdr_match(rx_hit)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_fwd_valid <= 1'b0;
      rx_drop <= 1'b0;
      rx_fwd_hdr <= '0;
    end else begin
      rx_fwd_valid <= rx_in_valid && rx_hit;
      rx_drop <= rx_in_valid && !rx_hit;
      if (rx_in_valid && rx_hit) begin
        rx_fwd_hdr <= rx_in_hdr;
      end
    end
  end

  // ----------------------------------------------------------------
  // screening counters, wrap at full scale
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accept_count <= '0;
    end else if (rx_in_valid && rx_hit) begin
      accept_count <= accept_count + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drop_count <= '0;
    end else if (rx_in_valid && !rx_hit) begin
      drop_count <= drop_count + 1'b1;
    end
  end

endmodule // ach_hdr_regs

// >>> ach_hdr_regs_chk.sv
// checker: port timing relations of the cell header block
`timescale 1ns/1ns
module ach_hdr_regs_chk
  import ach_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_in_valid,
  input wire logic tx_in_idle,
  input wire logic tx_out_valid,
  input wire logic tx_out_idle,
  input wire ach_hdr_type rx_in_hdr,
  input wire logic rx_in_valid,
  input wire ach_hdr_type rx_fwd_hdr,
  input wire logic rx_fwd_valid,
  input wire logic rx_drop,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_tx_latency: assert property (
    tx_in_valid |=> tx_out_valid && tx_out_idle == $past(tx_in_idle))
    else $error("transmit header not issued one cycle later");
  chk_tx_quiet: assert property (!tx_in_valid |=> !tx_out_valid)
    else $error("transmit output without input");
  chk_rx_verdict: assert property (rx_in_valid |=> rx_fwd_valid != rx_drop)
    else $error("receive cell needs exactly one verdict");
  chk_rx_quiet: assert property (!rx_in_valid |=> !rx_fwd_valid && !rx_drop)
    else $error("receive verdict without cell");
  chk_fwd_header: assert property (
    rx_in_valid ##1 rx_fwd_valid |-> rx_fwd_hdr == $past(rx_in_hdr))
    else $error("forwarded header differs from received");
  chk_fwd_keep: assert property (!rx_in_valid |=> $stable(rx_fwd_hdr))
    else $error("forwarded header changed without cell");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_b_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  chk_r_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
endmodule // ach_hdr_regs_chk

// >>> ach_atm_layer_model.sv
// partner: cell sink standing for the atm layer device
`timescale 1ns/1ns
module ach_atm_layer_model
  import ach_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire ach_hdr_type rx_fwd_hdr,
  input wire logic rx_fwd_valid,
  output logic [15:0] cells_taken,
  output ach_hdr_type last_hdr
);
  // always ready: the cell path has no back-pressure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cells_taken <= 16'h0000;
      last_hdr <= 32'h00000000;
    end else if (rx_fwd_valid) begin
      cells_taken <= cells_taken + 16'h0001;
      last_hdr <= rx_fwd_hdr;
    end
  end
endmodule // ach_atm_layer_model

// >>> ach_hdr_regs_bench.sv
// testbench: register access, header insertion and receive screening
`timescale 1ns/1ns
module ach_hdr_regs_bench;
  import ach_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  ach_hdr_type tx_in_hdr = 32'h00000000, rx_in_hdr = 32'h00000000;
  logic tx_in_valid = 1'b0, tx_in_idle = 1'b0, rx_in_valid = 1'b0;
  ach_hdr_type tx_out_hdr, rx_fwd_hdr, last_hdr;
  logic tx_out_valid, tx_out_idle, rx_fwd_valid, rx_drop;
  logic [15:0] cells_taken;
  int failures = 0, checks = 0, cycles = 0;
  // mode, select, expected header for user cell 0x12345678
  logic [43:0] utab [8] = '{44'h0_00_12345678, 44'h0_10_12345679, 44'h0_08_12345672,
    44'h0_04_1231C2C8, 44'h0_02_10C45678, 44'h0_01_C2345678, 44'h1_02_C0C45678,
    44'h1_01_12345678};

  ach_hdr_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_in_hdr(tx_in_hdr),
    .tx_in_valid(tx_in_valid), .tx_in_idle(tx_in_idle), .tx_out_hdr(tx_out_hdr),
    .tx_out_valid(tx_out_valid), .tx_out_idle(tx_out_idle), .rx_in_hdr(rx_in_hdr),
    .rx_in_valid(rx_in_valid), .rx_fwd_hdr(rx_fwd_hdr), .rx_fwd_valid(rx_fwd_valid),
    .rx_drop(rx_drop));
  ach_atm_layer_model u_far (.aclk(aclk), .aresetn(aresetn), .rx_fwd_hdr(rx_fwd_hdr),
    .rx_fwd_valid(rx_fwd_valid), .cells_taken(cells_taken), .last_hdr(last_hdr));

  // ----------------------------------------------------------------
  // clock, timeout, verdict
  // ----------------------------------------------------------------
  initial begin
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      aw_done = aw_done || (awvalid && awready);
      w_done = w_done || (wvalid && wready);
      if (aw_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end while (!(aw_done && w_done && bvalid));
    cmp({30'h0, bresp}, {30'h0, er}, "write response");
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    cmp(rdata, ed, "read data");
    cmp({30'h0, rresp}, {30'h0, er}, "read response");
    rready <= 1'b0;
  endtask
  task automatic tx(input ach_hdr_type h, input logic idle, input ach_hdr_type eh);
    @(posedge aclk);
    tx_in_hdr <= h;
    tx_in_idle <= idle;
    tx_in_valid <= 1'b1;
    @(posedge aclk);
    tx_in_valid <= 1'b0;
    #1;
    cmp(tx_out_hdr, eh, "transmit header");
    cmp({30'h0, tx_out_valid, tx_out_idle}, {30'h0, 1'b1, idle}, "transmit flags");
  endtask
  task automatic rx(input ach_hdr_type h, input logic acc);
    @(posedge aclk);
    rx_in_hdr <= h;
    rx_in_valid <= 1'b1;
    @(posedge aclk);
    rx_in_valid <= 1'b0;
    #1;
    cmp({30'h0, rx_fwd_valid, rx_drop}, {30'h0, acc, !acc}, "receive verdict");
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ACH_IDX_TX_HDR2 + 6'(i), (i == 6) ? 1 : 0, ACH_RESP_OKAY);
    tx(32'h12345678, 1'b1, 32'h00000001);
    $display("test reset values done");
    for (int i = 0; i < 9; i++) wr(ACH_IDX_TX_HDR1 + 6'(i), 8'hC0 + 8'(i), ACH_RESP_OKAY);
    for (int i = 0; i < 9; i++) rd(ACH_IDX_TX_HDR1 + 6'(i), 32'hC0 + i, ACH_RESP_OKAY);
    rd(6'h3F, 32'h00000000, ACH_RESP_SLVERR);
    wr(ACH_IDX_STATUS, 8'h5A, ACH_RESP_SLVERR);
    $display("test register access done");
    for (int i = 0; i < 8; i++) begin
      wr(ACH_IDX_MODE, {4'h0, utab[i][43:40]}, ACH_RESP_OKAY);
      wr(ACH_IDX_FIELD_SEL, utab[i][39:32], ACH_RESP_OKAY);
      tx(32'h12345678, 1'b0, utab[i][31:0]);
      tx(32'h12345678, 1'b1, 32'hC4C5C6C7);
    end
    $display("test transmit insertion done");
    rx(32'h12345678, 1'b1);
    wr(ACH_IDX_RX_MSK1, 8'h0F, ACH_RESP_OKAY);
    rx(32'hC3000000, 1'b1);
    rx(32'hD3000000, 1'b0);
    for (int i = 0; i < 4; i++) wr(ACH_IDX_RX_MSK1 + 6'(i), 8'h00, ACH_RESP_OKAY);
    for (int i = 1; i < 4; i++) wr(ACH_IDX_RX_HDR1 + 6'(i), 8'h00, ACH_RESP_OKAY);
    rx(32'hC8000000, 1'b1);
    rx(32'hC8000001, 1'b0);
    cmp({16'h0, cells_taken}, 32'h3, "cells at far side");
    cmp(last_hdr, 32'hC8000000, "last cell at far side");
    rd(ACH_IDX_STATUS, 32'h00020003, ACH_RESP_OKAY);
    $display("test receive screening done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ACH_IDX_IDLE_HDR4, 32'h01, ACH_RESP_OKAY);
    rd(ACH_IDX_RX_HDR1, 32'h00, ACH_RESP_OKAY);
    rd(ACH_IDX_RX_MSK1, 32'hFF, ACH_RESP_OKAY);
    rd(ACH_IDX_STATUS, 32'h00000000, ACH_RESP_OKAY);
    $display("test second reset done");
    wrap_up();
  end
endmodule // ach_hdr_regs_bench

bind ach_hdr_regs ach_hdr_regs_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .tx_in_valid(tx_in_valid), .tx_in_idle(tx_in_idle), .tx_out_valid(tx_out_valid),
  .tx_out_idle(tx_out_idle), .rx_in_hdr(rx_in_hdr), .rx_in_valid(rx_in_valid),
  .rx_fwd_hdr(rx_fwd_hdr), .rx_fwd_valid(rx_fwd_valid), .rx_drop(rx_drop),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
